// [src/mcs_pkg.sv]
// Purpose: Shared constants and types of the measurement cycle sequencer
// Assumes: 100 MHz system clock, classic Wishbone register access
// Notes: Config field layout matches the cycle configuration word
//==========================================================
// Package
package mcs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;

  localparam int CFG_W = 13;
  localparam logic [12:0] CFG_RESET = 13'h0062;

  localparam logic [3:0] RES1_MIN = 4'h9;
  localparam logic [3:0] RES1_MAX = 4'hE;
  localparam logic [3:0] RES2_MIN = 4'hB;
  localparam logic [3:0] RES2_MAX = 4'hF;
  localparam logic [3:0] ANALOG_RES_CAP = 4'hB;
  localparam logic [3:0] PWM_RES_CAP = 4'hC;
  localparam logic [3:0] ORDER2_ADD = 4'h3;

  localparam logic [3:0] START_LAST = 4'h3;
  localparam logic [3:0] CYCLE_LAST = 4'hB;
  localparam logic [3:0] T2_FIRST = 4'h6;
  localparam logic [3:0] T2_LAST = 4'h9;

  localparam int FIFO_DEPTH = 8;
  localparam int RESULT_W = 16;

  typedef enum logic [2:0] {
    STEP_BRIDGE = 3'h0,
    STEP_BR_AZ = 3'h1,
    STEP_T1_AZ = 3'h2,
    STEP_T1 = 3'h3,
    STEP_T2_AZ = 3'h4,
    STEP_T2 = 3'h5,
    STEP_CM = 3'h6
  } mcs_step_e;

  typedef enum logic [2:0] {
    S_PICK = 3'b001,
    S_CONV = 3'b010,
    S_PUSH = 3'b100
  } mcs_state_e;

  // Same bit order as the configuration word, bit 12 down to bit 0
  typedef struct packed {
    logic ref_sel;
    logic [1:0] range_shift;
    logic [2:0] rep_code;
    logic [3:0] res;
    logic order2;
    logic t1e;
    logic t2e;
  } mcs_cfg_s;

  typedef struct packed {
    mcs_step_e kind;
    logic [RESULT_W-1:0] value;
  } mcs_result_s;
endpackage

// [src/mcs_top.sv]
// Purpose: Measurement cycle sequencer and charge-balancing ADC control
// Assumes: Comparator bitstream from the analog front end, Wishbone master
// Notes: Results leave tagged through an 8-word FIFO to the correction logic
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/10ps

//==========================================================
// FIFO
module mcs_fifo #(
  parameter int W = 19,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D+1)-1:0] level_o
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D+1);
  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two");
  end
  logic [W-1:0] mem_r [D];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = (cnt_r != CW'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];
  assign level_o = cnt_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end
endmodule

//==========================================================
// Sequencer top
module mcs_top #(
  parameter int TICK_CYC = mcs_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic adc_bit_i,
  output logic [1:0] mux_sel_o,
  output logic mux_short_o,
  output logic conv_active_o,
  output logic adc_ref_sel_o,
  output logic res_valid_o,
  input wire logic res_ready_i,
  output mcs_pkg::mcs_result_s res_data_o
);
  if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_chk
    $error("TICK_CYC out of range");
  end

  //==========================================================
  // State
  mcs_pkg::mcs_cfg_s cfg_r, cfg_nxt;
  mcs_pkg::mcs_state_e state_r, state_nxt;
  mcs_pkg::mcs_step_e kind_r, kind_nxt;
  mcs_pkg::mcs_result_s last_r, last_nxt;
  logic start_r, start_nxt;
  logic [3:0] idx_r, idx_nxt, res_r, res_nxt, len_r, len_nxt;
  logic [7:0] rep_r, rep_nxt;
  logic [15:0] tick_r, tick_nxt, left_r, left_nxt, ones_r, ones_nxt;
  logic [15:0] val_r, val_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic bit_s1_r, bit_s2_r;
  logic fifo_ready;
  logic [3:0] fifo_level;

  //==========================================================
  // Step tables
  function automatic mcs_pkg::mcs_step_e slot_kind(input logic st, input logic [3:0] i);
    if (st) begin
      unique case (i[1:0])
        2'h0: slot_kind = mcs_pkg::STEP_BRIDGE;
        2'h1: slot_kind = mcs_pkg::STEP_BR_AZ;
        2'h2: slot_kind = mcs_pkg::STEP_T1;
        2'h3: slot_kind = mcs_pkg::STEP_T1_AZ;
      endcase
    end else begin
      case (i)
        4'h1: slot_kind = mcs_pkg::STEP_T1_AZ;
        4'h3: slot_kind = mcs_pkg::STEP_T1;
        4'h5: slot_kind = mcs_pkg::STEP_BR_AZ;
        4'h7: slot_kind = mcs_pkg::STEP_T2_AZ;
        4'h9: slot_kind = mcs_pkg::STEP_T2;
        4'hB: slot_kind = mcs_pkg::STEP_CM;
        default: slot_kind = mcs_pkg::STEP_BRIDGE;
      endcase
    end
  endfunction

  function automatic logic slot_on(input logic st, input logic [3:0] i, input mcs_pkg::mcs_cfg_s c);
    if (st) begin
      slot_on = (i < 4'h2) || c.t1e;
    end else begin
      slot_on = !(i >= mcs_pkg::T2_FIRST && i <= mcs_pkg::T2_LAST) || c.t2e;
    end
  endfunction

  function automatic logic [3:0] res_eff(input mcs_pkg::mcs_cfg_s c);
    logic [3:0] lo, hi;
    lo = c.order2 ? mcs_pkg::RES2_MIN : mcs_pkg::RES1_MIN;
    hi = c.order2 ? mcs_pkg::RES2_MAX : mcs_pkg::RES1_MAX;
    res_eff = (c.res < lo) ? lo : ((c.res > hi) ? hi : c.res);
  endfunction

  //==========================================================
  // Sequencer next state
  logic last_slot, tick_end, advance;
  logic [3:0] r_eff, l_eff;
  logic [15:0] ones_fin;
  logic [17:0] scaled, offset;
  logic [4:0] up_shift;

  assign r_eff = res_eff(cfg_r);
  assign l_eff = cfg_r.order2 ?
                 4'((5'(r_eff) + 5'(mcs_pkg::ORDER2_ADD)) >> 1) : r_eff;
  assign last_slot = (idx_r == (start_r ? mcs_pkg::START_LAST : mcs_pkg::CYCLE_LAST));
  assign tick_end = (tick_r == 16'(TICK_CYC - 1));
  assign ones_fin = ones_r + {15'h0, bit_s2_r};
  assign up_shift = 5'(res_r) + 5'h1 - 5'(len_r);
  assign scaled = 18'(ones_fin) << up_shift;
  assign offset = (18'h1 << res_r) - (18'h1 << (res_r - 4'h1 - {2'h0, cfg_r.range_shift}));
  assign advance = (state_r == mcs_pkg::S_PUSH) && fifo_ready && (rep_r == 8'h0);

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    start_nxt = start_r;
    idx_nxt = idx_r;
    rep_nxt = rep_r;
    tick_nxt = tick_r;
    left_nxt = left_r;
    ones_nxt = ones_r;
    val_nxt = val_r;
    res_nxt = res_r;
    len_nxt = len_r;
    last_nxt = last_r;
    unique case (state_r)
      mcs_pkg::S_PICK: begin
        kind_nxt = slot_kind(start_r, idx_r);
        if (slot_on(start_r, idx_r, cfg_r)) begin
          rep_nxt = (!start_r && slot_kind(start_r, idx_r) == mcs_pkg::STEP_BRIDGE) ?
                    8'((9'h1 << cfg_r.rep_code) - 9'h1) : 8'h0;
          res_nxt = r_eff;
          len_nxt = l_eff;
          left_nxt = 16'h1 << l_eff;
          tick_nxt = 16'h0;
          ones_nxt = 16'h0;
          state_nxt = mcs_pkg::S_CONV;
        end else if (last_slot) begin
          idx_nxt = 4'h0;
          start_nxt = 1'b0;
        end else begin
          idx_nxt = idx_r + 4'h1;
        end
      end
      mcs_pkg::S_CONV: begin
        tick_nxt = tick_end ? 16'h0 : tick_r + 16'h1;
        if (tick_end) begin
          ones_nxt = ones_fin;
          left_nxt = left_r - 16'h1;
          if (left_r == 16'h1) begin
            if (scaled < offset) begin
              val_nxt = 16'h0;
            end else if ((scaled - offset) > 18'h0FFFF) begin
              val_nxt = 16'hFFFF;
            end else begin
              val_nxt = 16'(scaled - offset);
            end
            state_nxt = mcs_pkg::S_PUSH;
          end
        end
      end
      mcs_pkg::S_PUSH: begin
        if (fifo_ready) begin
          last_nxt = '{kind: kind_r, value: val_r};
          if (rep_r != 8'h0) begin
            rep_nxt = rep_r - 8'h1;
            left_nxt = 16'h1 << len_r;
            tick_nxt = 16'h0;
            ones_nxt = 16'h0;
            state_nxt = mcs_pkg::S_CONV;
          end else begin
            state_nxt = mcs_pkg::S_PICK;
            if (last_slot) begin
              idx_nxt = 4'h0;
              start_nxt = 1'b0;
            end else begin
              idx_nxt = idx_r + 4'h1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= mcs_pkg::S_PICK;
      kind_r <= mcs_pkg::STEP_BRIDGE;
      start_r <= 1'b1;
      idx_r <= 4'h0;
      rep_r <= 8'h0;
      tick_r <= 16'h0;
      left_r <= 16'h0;
      ones_r <= 16'h0;
      val_r <= 16'h0;
      res_r <= mcs_pkg::RES1_MIN;
      len_r <= mcs_pkg::RES1_MIN;
      last_r <= '0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      start_r <= start_nxt;
      idx_r <= idx_nxt;
      rep_r <= rep_nxt;
      tick_r <= tick_nxt;
      left_r <= left_nxt;
      ones_r <= ones_nxt;
      val_r <= val_nxt;
      res_r <= res_nxt;
      len_r <= len_nxt;
      last_r <= last_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    bit_s1_r <= adc_bit_i;
    bit_s2_r <= bit_s1_r;
  end

  //==========================================================
  // Front end control
  assign conv_active_o = (state_r == mcs_pkg::S_CONV);
  assign mux_short_o = (kind_r == mcs_pkg::STEP_BR_AZ) || (kind_r == mcs_pkg::STEP_T1_AZ) ||
                       (kind_r == mcs_pkg::STEP_T2_AZ);
  assign mux_sel_o = (kind_r == mcs_pkg::STEP_CM) ? 2'h3 :
                     (kind_r == mcs_pkg::STEP_T2 || kind_r == mcs_pkg::STEP_T2_AZ) ? 2'h2 :
                     (kind_r == mcs_pkg::STEP_T1 || kind_r == mcs_pkg::STEP_T1_AZ) ? 2'h1 : 2'h0;
  assign adc_ref_sel_o = cfg_r.ref_sel;

  mcs_fifo #(.W($bits(mcs_pkg::mcs_result_s)), .D(mcs_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(state_r == mcs_pkg::S_PUSH),
    .in_ready_o(fifo_ready),
    .in_data_i({kind_r, val_r}),
    .out_valid_o(res_valid_o),
    .out_ready_i(res_ready_i),
    .out_data_o(res_data_o),
    .level_o(fifo_level)
  );

  //==========================================================
  // Wishbone slave
  logic req;
  logic [3:0] ana_cap, pwm_cap;
  assign req = cyc_i && stb_i;
  assign ana_cap = (r_eff > mcs_pkg::ANALOG_RES_CAP) ? mcs_pkg::ANALOG_RES_CAP : r_eff;
  assign pwm_cap = (r_eff > mcs_pkg::PWM_RES_CAP) ? mcs_pkg::PWM_RES_CAP : r_eff;

  always_comb begin
    ack_nxt = req && !ack_r;
    dat_nxt = dat_r;
    cfg_nxt = cfg_r;
    if (ack_nxt) begin
      unique case (adr_i)
        mcs_pkg::ADDR_CFG: dat_nxt = {19'h0, cfg_r};
        mcs_pkg::ADDR_STATUS: dat_nxt = {7'h0, start_r, 4'h0, fifo_level, pwm_cap, ana_cap,
                                         r_eff, 1'b0, kind_r};
        mcs_pkg::ADDR_RESULT: dat_nxt = {13'h0, last_r};
        default: dat_nxt = 32'h0;
      endcase
    end
    if (ack_r && req && we_i && adr_i == mcs_pkg::ADDR_CFG) begin
      if (sel_i[0]) begin
        cfg_nxt[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        cfg_nxt[12:8] = dat_i[12:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      cfg_r <= mcs_pkg::CFG_RESET;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  //==========================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_follows_req: assert property ((req && !ack_o) |=> ack_o)
    else $error("ack missing after request");
  a_rep_count_load: assert property ((state_r == mcs_pkg::S_PICK && !start_r &&
      slot_on(start_r, idx_r, cfg_r) && slot_kind(start_r, idx_r) == mcs_pkg::STEP_BRIDGE)
      |=> rep_r == 8'((9'h1 << $past(cfg_r.rep_code)) - 9'h1))
    else $error("bridge repetition count wrong");
  a_t2_steps_skipped: assert property ((state_r == mcs_pkg::S_PICK && !start_r &&
      idx_r >= mcs_pkg::T2_FIRST && idx_r <= mcs_pkg::T2_LAST && !cfg_r.t2e)
      |=> state_r == mcs_pkg::S_PICK)
    else $error("temperature 2 step not skipped");
  a_cycle_wraps_zero: assert property ((advance && !start_r && idx_r == mcs_pkg::CYCLE_LAST)
      |=> idx_r == 4'h0 && state_r == mcs_pkg::S_PICK)
    else $error("cycle did not restart");
  a_start_leaves_once: assert property ((advance && start_r && idx_r == mcs_pkg::START_LAST)
      |=> !start_r && idx_r == 4'h0)
    else $error("start routine did not hand over");
  a_short_only_az: assert property ((conv_active_o && kind_r == mcs_pkg::STEP_BRIDGE)
      |-> !mux_short_o && mux_sel_o == 2'h0)
    else $error("bridge step shorted");
  a_push_stall_hold: assert property ((state_r == mcs_pkg::S_PUSH && !fifo_ready)
      |=> state_r == mcs_pkg::S_PUSH && $stable(val_r) && $stable(kind_r))
    else $error("result lost under back-pressure");
  a_res_range_held: assert property ((state_r == mcs_pkg::S_CONV) |-> (res_r >=
      mcs_pkg::RES1_MIN && res_r <= mcs_pkg::RES2_MAX && len_r <= res_r))
    else $error("conversion resolution out of range");
  a_output_caps: assert property (ana_cap <= mcs_pkg::ANALOG_RES_CAP &&
      pwm_cap <= mcs_pkg::PWM_RES_CAP)
    else $error("output resolution cap exceeded");
endmodule

// [tb/mcs_front_model.sv]
// Purpose: Front end model driving the comparator bitstream
// Assumes: Sensor input held constant through a test
// Notes: Shorted input shows only the channel offset level
`timescale 1ns/10ps
//==========================================================
// Front end model
module mcs_front_model (
  input wire logic clk_i,
  input wire logic mux_short_i,
  input wire logic sig_lvl_i,
  input wire logic off_lvl_i,
  output logic adc_bit_o
);
  initial adc_bit_o = 1'b0;
  always @(posedge clk_i) begin
    adc_bit_o <= mux_short_i ? off_lvl_i : sig_lvl_i;
  end
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench of the measurement cycle sequencer
// Assumes: Short ADC tick parameter, constant full-scale input
// Notes: Checks step order, mux, values, stall, rates and caps
`timescale 1ns/10ps
//==========================================================
// Bench
module tb;
  localparam int TK = 2;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, adc_bit_i, mux_short_o, conv_active_o;
  logic adc_ref_sel_o, res_valid_o, res_ready_i, lvl;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [3:0] sel_i;
  logic [1:0] mux_sel_o;
  mcs_pkg::mcs_result_s res_data_o;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  int len = 0;
  int last_len = 0;
  logic [18:0] got_q[$];
  logic [2:0] cv_q[$];
  logic [2:0] exp_q[$];
  logic [11:0] tab_cfg[3] = '{12'h042, 12'h04E, 12'h07E};
  logic [11:0] tab_st[3] = '{12'h999, 12'hBBB, 12'hCBF};
  int tab_len[3] = '{512 * TK, 128 * TK, 512 * TK};

  mcs_top #(.TICK_CYC(TK)) mcs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .adc_bit_i(adc_bit_i), .mux_sel_o(mux_sel_o), .mux_short_o(mux_short_o),
    .conv_active_o(conv_active_o), .adc_ref_sel_o(adc_ref_sel_o), .res_valid_o(res_valid_o),
    .res_ready_i(res_ready_i), .res_data_o(res_data_o));
  mcs_front_model mcs_front_model_inst (.clk_i(clk_i), .mux_short_i(mux_short_o),
    .sig_lvl_i(lvl), .off_lvl_i(lvl), .adc_bit_o(adc_bit_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  //==========================================================
  // Monitor and watchdog
  always @(posedge clk_i) begin
    cyc_cnt = cyc_cnt + 1;
    if (res_valid_o === 1'b1 && res_ready_i === 1'b1) got_q.push_back(res_data_o);
    if (conv_active_o === 1'b1) begin
      if (len == 0) cv_q.push_back({mux_sel_o, mux_short_o});
      len = len + 1;
    end else if (len != 0) begin
      last_len = len;
      len = 0;
    end
    if (cyc_cnt == 90000) begin
      num_errors++;
      complete_run();
    end
  end

  //==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(32'({ack_o, res_valid_o, conv_active_o, mux_sel_o, mux_short_o, adc_ref_sel_o}), 0);
    got_q.delete();
    cv_q.delete();
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [2:0] mux_of(input logic [2:0] k);
    case (k)
      3'h0: return 3'b000;
      3'h1: return 3'b001;
      3'h2: return 3'b011;
      3'h3: return 3'b010;
      3'h4: return 3'b101;
      3'h5: return 3'b100;
      default: return 3'b110;
    endcase
  endfunction

  // Start routine, one full cycle, then the first step of the next
  task automatic build(input bit t2, input int n);
    logic [2:0] s[$];
    exp_q = '{3'h0, 3'h1, 3'h3, 3'h2};
    if (t2) begin
      s = '{3'h2, 3'h3, 3'h1, 3'h4, 3'h5, 3'h6};
    end else begin
      s = '{3'h2, 3'h3, 3'h1, 3'h6};
    end
    foreach (s[i]) begin
      repeat (n) exp_q.push_back(3'h0);
      exp_q.push_back(s[i]);
    end
    exp_q.push_back(3'h0);
  endtask

  task automatic check_seq(input logic [15:0] val);
    while (got_q.size() < exp_q.size()) @(posedge clk_i);
    foreach (exp_q[i]) begin
      chk(32'(got_q[i][18:16]), 32'(exp_q[i]));
      chk(32'(cv_q[i]), 32'(mux_of(exp_q[i])));
      if (i > 0) chk(32'(got_q[i][15:0]), 32'(val));
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  //==========================================================
  // Tests
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'hF;
    res_ready_i = 1'b0;
    lvl = 1'b1;
    do_reset();
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0062);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h00, 32'h0000_00DF);
    rd = 32'h0;
    while (rd[19:16] !== 4'h8) wb(1'b0, 8'h04, 32'h0);
    repeat (600) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk(32'(rd[19:16]), 32'h8);
    chk(32'({conv_active_o, res_valid_o}), 32'h1);
    res_ready_i <= 1'b1;
    build(1'b1, 2);
    check_seq(16'h0C00);
    wb(1'b0, 8'h08, 32'h0);
    chk(32'(rd[15:0]), 32'h0C00);
    $display("test stall and full cycle done");
    do_reset();
    wb(1'b1, 8'h00, 32'h0000_1C5E);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_1C5E);
    chk(32'(adc_ref_sel_o), 32'h1);
    build(1'b0, 1);
    check_seq(16'h0880);
    wb(1'b0, 8'h08, 32'h0);
    chk(32'(rd[15:0]), 32'h0880);
    $display("test range shift and short cycle done");
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 8'h00, 32'(tab_cfg[i]));
      @(posedge conv_active_o);
      @(posedge conv_active_o);
      @(negedge conv_active_o);
      repeat (2) @(posedge clk_i);
      wb(1'b0, 8'h04, 32'h0);
      chk(32'(rd[15:4]), 32'(tab_st[i]));
      chk(32'(last_len), 32'(tab_len[i]));
    end
    $display("test resolution and rate done");
    complete_run();
  end
endmodule
